// [rtl/xp_pkg.sv]
package xp_pkg;

    // ------------------------------------------------------------
    // Link framing and addressing
    // ------------------------------------------------------------
    localparam int SYNC_W = 5;
    localparam int STRAP_W = 2;
    localparam logic [4:0] SLV_ADDR_HI = 5'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_NONE = 4'h0;

    // ------------------------------------------------------------
    // Register space
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam int SEL_W = 5;
    localparam logic [7:0] TAP_SEL_REG = 8'h30;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [4:0] TAP_SEL_RST = 5'h00;

    // ------------------------------------------------------------
    // Transfer states
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_PTR = 6'h04,
        ST_WDATA = 6'h08,
        ST_RD = 6'h10,
        ST_IGN = 6'h20
    } xp_state_t;

    // Own seven-bit address from the straps
    function automatic logic [6:0] xp_own_addr(input logic [1:0] strap);
        return {SLV_ADDR_HI, strap};
    endfunction

    // Register pointer advance, wraps at the top
    function automatic logic [7:0] xp_ptr_inc(input logic [7:0] ptr);
        return ptr + 8'h01;
    endfunction

endpackage

// [rtl/xp_sync.sv]
`timescale 1ns/1ps
module xp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input logic clk,          // Destination clock
    input logic reset,        // Synchronous reset, high
    input logic [W-1:0] d,    // Asynchronous inputs
    output logic [W-1:0] q    // Synchronised outputs
);

    logic [W-1:0] meta_q;

    // Two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= RST;
            q <= RST;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// [rtl/xp_regmem.sv]
`timescale 1ns/1ps
module xp_regmem (
    input logic clk,                           // System clock
    input logic reset,                         // Synchronous reset, high
    input logic we,                            // Write strobe
    input logic [xp_pkg::ADDR_W-1:0] waddr,    // Write address
    input logic [xp_pkg::DATA_W-1:0] wdata,    // Write data
    input logic [xp_pkg::ADDR_W-1:0] raddr,    // Read address
    output logic [xp_pkg::DATA_W-1:0] rdata    // Registered read data
);
    import xp_pkg::*;

    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // Write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule

// [rtl/xp_i2c_cfg_slave.sv]
// Behaviour
// - The first byte after a start holds the slave address in bits 7:1 and direction in bit 0.
// - Address bits 1:0 come from the two straps, strap 0 giving bit 0.
// - Address bits 6:2 are zero, so the device answers at 0000000 to 0000011.
// - Direction 0 means write: pointer byte then data bytes follow.
// - The master releases SDA in the acknowledge clock and the device holds it low.
// - Each further write data byte goes to the next register as the pointer advances.
// - Every data byte is acknowledged and writing goes on until a stop.
// - A seventeenth unity-gain tap output has its own input selection like the others.
// - A read is a pointer-only write then a read that returns and advances until the master NACKs.
`timescale 1ns/1ps
module xp_i2c_cfg_slave (
    input logic sys_clk,                           // System clock, 50 MHz
    input logic reset,                             // Synchronous reset, high; asynchronous for the link-side flops
    input logic scl_clk,                           // Serial clock from the master
    input logic sda_in,                            // Serial data level on the wire
    output logic sda_out,                          // Serial data drive value, always low
    output logic sda_oe,                           // High while pulling SDA low
    input logic [xp_pkg::STRAP_W-1:0] addr_strap,  // Address straps
    output logic [xp_pkg::SEL_W-1:0] sync_tap_sel, // Input routed to the tap output
    output logic link_busy                         // Transfer in progress
);
    import xp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync_s;
    logic scl_s, sda_s, lnk_tgl_s;
    logic [STRAP_W-1:0] strap_s;
    logic scl_d_q, sda_d_q, tgl_d_q;
    logic start_det, stop_det, scl_rise, scl_fall, byte_evt;
    logic start_tgl_q;
    logic lnk_seen_q, lnk_tgl_q;
    logic [3:0] lnk_cnt_q;
    logic [7:0] lnk_shift_q, lnk_byte_q;
    xp_state_t st_q;
    logic [3:0] bit_q, bit_d;
    logic ack_want_q;
    logic sda_oe_q;
    logic [7:0] ptr_q;
    logic [7:0] rd_data;
    logic addr_match;
    logic mem_we;
    logic [SEL_W-1:0] tap_sel_q;

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;
    assign sync_tap_sel = tap_sel_q;
    assign link_busy = (st_q != ST_IDLE);

    // ------------------------------------------------------------
    // Pin and link byte toggle synchronisers
    // ------------------------------------------------------------
    xp_sync #(
        .W(SYNC_W),
        .RST(5'h03)
    ) u_sync (
        .clk(sys_clk),
        .reset(reset),
        .d({lnk_tgl_q, addr_strap, sda_in, scl_clk}),
        .q(sync_s)
    );

    assign scl_s = sync_s[0];
    assign sda_s = sync_s[1];
    assign strap_s = sync_s[3:2];
    assign lnk_tgl_s = sync_s[4];

    // Previous samples for edge detection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
            tgl_d_q <= 1'b0;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
            tgl_d_q <= lnk_tgl_s;
        end
    end

    // Start and stop are SDA edges with SCL held high
    assign start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;
    assign scl_rise = scl_s & ~scl_d_q;
    assign scl_fall = ~scl_s & scl_d_q;
    assign byte_evt = lnk_tgl_s ^ tgl_d_q;

    // Start toggle handed to the link side
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            start_tgl_q <= 1'b0;
        end else if (start_det) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // Link domain: bit capture on SCL rising edges
    // ------------------------------------------------------------
    // The start toggle settles about 400 ns before the first SCL rise
    // of a frame, so it is read without further staging. Reset is
    // applied asynchronously because SCL stands still during reset.
    always_ff @(posedge scl_clk or posedge reset) begin
        if (reset) begin
            lnk_seen_q <= 1'b0;
            lnk_cnt_q <= BIT_NONE;
            lnk_shift_q <= 8'h00;
            lnk_byte_q <= 8'h00;
            lnk_tgl_q <= 1'b0;
        end else if (lnk_seen_q != start_tgl_q) begin
            lnk_seen_q <= start_tgl_q;
            lnk_shift_q <= {7'h00, sda_in};
            lnk_cnt_q <= BIT_FIRST;
        end else if (lnk_cnt_q == BIT_ACK) begin
            lnk_cnt_q <= BIT_NONE; // Acknowledge clock, nothing shifted
        end else begin
            lnk_shift_q <= {lnk_shift_q[6:0], sda_in};
            lnk_cnt_q <= lnk_cnt_q + 4'h1;
            if (lnk_cnt_q == BIT_LAST) begin
                lnk_byte_q <= {lnk_shift_q[6:0], sda_in};
                lnk_tgl_q <= ~lnk_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Bit position on SCL falling edges, system domain
    // ------------------------------------------------------------
    assign bit_d = (bit_q == BIT_ACK) ? BIT_NONE : bit_q + 4'h1;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bit_q <= BIT_ACK;
        end else if (start_det) begin
            bit_q <= BIT_ACK;
        end else if (scl_fall) begin
            bit_q <= bit_d;
        end
    end

    // ------------------------------------------------------------
    // Transfer state machine
    // ------------------------------------------------------------
    assign addr_match = (lnk_byte_q[7:1] == xp_own_addr(strap_s));

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
        end else if (start_det) begin
            st_q <= ST_ADDR;
        end else if (stop_det) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_ADDR: begin
                    if (byte_evt) begin
                        if (!addr_match) begin
                            st_q <= ST_IGN;
                        end else if (lnk_byte_q[0]) begin
                            st_q <= ST_RD;
                        end else begin
                            st_q <= ST_PTR;
                        end
                    end
                end
                ST_PTR: begin
                    if (byte_evt) begin
                        st_q <= ST_WDATA;
                    end
                end
                ST_RD: begin
                    if (scl_rise && bit_q == BIT_ACK && !sda_oe_q && sda_s) begin
                        st_q <= ST_IGN; // Master declined more data
                    end
                end
                default: begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    // Acknowledge request for the byte just received
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_want_q <= 1'b0;
        end else if (byte_evt && st_q == ST_ADDR) begin
            ack_want_q <= addr_match;
        end else if (byte_evt && (st_q == ST_PTR || st_q == ST_WDATA)) begin
            ack_want_q <= 1'b1;
        end else if (start_det || stop_det || (scl_fall && bit_d == BIT_NONE)) begin
            ack_want_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register pointer and register file
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ptr_q <= PTR_RST;
        end else if (byte_evt && st_q == ST_PTR) begin
            ptr_q <= lnk_byte_q;
        end else if (byte_evt && st_q == ST_WDATA) begin
            ptr_q <= xp_ptr_inc(ptr_q);
        end else if (st_q == ST_RD && scl_rise && bit_q == BIT_ACK && !sda_oe_q && !sda_s) begin
            ptr_q <= xp_ptr_inc(ptr_q);
        end
    end

    assign mem_we = byte_evt && (st_q == ST_WDATA);

    xp_regmem u_mem (
        .clk(sys_clk),
        .reset(reset),
        .we(mem_we),
        .waddr(ptr_q),
        .wdata(lnk_byte_q),
        .raddr(ptr_q),
        .rdata(rd_data)
    );

    // Shadow of the tap output selection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tap_sel_q <= TAP_SEL_RST;
        end else if (mem_we && ptr_q == TAP_SEL_REG) begin
            tap_sel_q <= lnk_byte_q[SEL_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // SDA drive, set on SCL falls, cleared by start and stop
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sda_oe_q <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_q <= 1'b0;
        end else if (scl_fall) begin
            if (bit_d == BIT_ACK) begin
                sda_oe_q <= ack_want_q;
            end else if (st_q == ST_RD) begin
                sda_oe_q <= ~rd_data[3'(BIT_LAST - bit_d)];
            end else begin
                sda_oe_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_addr_dir_read;
        @(posedge sys_clk) disable iff (reset)
        (st_q == ST_ADDR && byte_evt && !start_det && !stop_det && addr_match
            && lnk_byte_q[0]) |=> (st_q == ST_RD);
    endproperty
    a_addr_dir_read: assert property (p_addr_dir_read) else $error("read address not taken");

    property p_strap_match;
        @(posedge sys_clk) disable iff (reset)
        (st_q == ST_ADDR && byte_evt && !start_det && !stop_det
            && lnk_byte_q[2:1] == strap_s && lnk_byte_q[7:3] == 5'h00)
            |=> (st_q != ST_IGN);
    endproperty
    a_strap_match: assert property (p_strap_match) else $error("strap address refused");

    property p_high_bits_zero;
        @(posedge sys_clk) disable iff (reset)
        (st_q == ST_ADDR && byte_evt && !start_det && !stop_det && lnk_byte_q[7:3] != 5'h00)
            |=> (st_q == ST_IGN);
    endproperty
    a_high_bits_zero: assert property (p_high_bits_zero) else $error("nonzero high bits taken");

    property p_write_dir;
        @(posedge sys_clk) disable iff (reset)
        (st_q == ST_ADDR && byte_evt && !start_det && !stop_det && addr_match
            && !lnk_byte_q[0]) |=> (st_q == ST_PTR);
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("write address not taken");

    property p_ack_drive;
        @(posedge sys_clk) disable iff (reset)
        (scl_fall && bit_q == BIT_LAST && ack_want_q && !start_det && !stop_det)
            |=> sda_oe_q ##1 (sda_oe_q || scl_fall || stop_det || start_det);
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

    property p_ptr_advance;
        @(posedge sys_clk) disable iff (reset)
        (st_q == ST_WDATA && byte_evt && !start_det && !stop_det)
            |=> (ptr_q == xp_ptr_inc($past(ptr_q)));
    endproperty
    a_ptr_advance: assert property (p_ptr_advance) else $error("pointer did not advance");

    property p_stop_ends;
        @(posedge sys_clk) disable iff (reset)
        (stop_det && !start_det) |=> (st_q == ST_IDLE && !sda_oe_q && !link_busy);
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop did not end transfer");

    property p_tap_sel;
        @(posedge sys_clk) disable iff (reset)
        (mem_we && ptr_q == TAP_SEL_REG) |=> (sync_tap_sel == $past(lnk_byte_q[SEL_W-1:0]));
    endproperty
    a_tap_sel: assert property (p_tap_sel) else $error("tap selection not updated");

    property p_read_advance;
        @(posedge sys_clk) disable iff (reset)
        (st_q == ST_RD && scl_rise && bit_q == BIT_ACK && !sda_oe_q && !sda_s
            && !start_det && !stop_det) |=> (ptr_q == xp_ptr_inc($past(ptr_q)));
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("read pointer stuck");

    property p_foreign_silent;
        @(posedge sys_clk) disable iff (reset)
        (st_q == ST_IGN) |-> !sda_oe_q;
    endproperty
    a_foreign_silent: assert property (p_foreign_silent) else $error("drive while ignoring");

    // Main scenarios
    c_burst_write: cover property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_WDATA && byte_evt ##[1:1000] st_q == ST_WDATA && byte_evt);
    c_read: cover property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_RD && scl_fall && bit_d == BIT_NONE);
    c_foreign: cover property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_IGN ##[1:1000] stop_det);

endmodule

// [tb/xp_master_model.sv]
`timescale 1ns/1ps
module xp_master_model (
    output logic scl,          // Serial clock to the slave
    output logic sda_low,      // High while the master pulls SDA low
    input wire logic sda_wire  // Resolved SDA level, pulled up
);
    // ------------------------------------------------------------
    // Link timebase, 15 ns, SCL still outside frames
    // ------------------------------------------------------------
    localparam int PH = 16;  // Ticks per SCL phase, 240 ns
    logic lclk = 1'b0;
    always #7.5 lclk = ~lclk;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
    endtask

    // ------------------------------------------------------------
    // Frame conditions
    // ------------------------------------------------------------
    // Start or repeated start, SDA falls while SCL high
    task automatic start_cond();
        sda_low <= 1'b0;
        tick(PH / 2);
        scl <= 1'b1;
        tick(PH);
        sda_low <= 1'b1;
        tick(PH);
        scl <= 1'b0;
        tick(PH / 2);
    endtask

    // Stop, SDA rises while SCL high
    task automatic stop_cond();
        sda_low <= 1'b1;
        tick(PH / 2);
        scl <= 1'b1;
        tick(PH);
        sda_low <= 1'b0;
        tick(PH);
    endtask

    // One clock: drive bit, sample wire mid high phase
    task automatic xfer_bit(input logic b, output logic r);
        sda_low <= ~b;
        tick(PH / 2);
        scl <= 1'b1;
        tick(PH / 2);
        r = sda_wire;
        tick(PH / 2);
        scl <= 1'b0;
        tick(PH / 2);
    endtask

    // Byte out MSB first, then release for the acknowledge
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(v[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    // Byte in MSB first, then master ACK or NACK
    task automatic recv_byte(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            v[i] = r;
        end
        xfer_bit(~ack, r);
    endtask
endmodule

// [tb/test_xp_i2c_cfg_slave.sv]
`timescale 1ns/1ps
module test_xp_i2c_cfg_slave;
    import xp_pkg::*;

    logic sys_clk = 1'b0;
    logic reset = 1'b0;
    logic [1:0] addr_strap = 2'h0;
    logic scl;
    logic m_sda_low;
    logic sda_out;
    logic sda_oe;
    logic [4:0] sync_tap_sel;
    logic link_busy;
    wire logic sda_wire = ~(m_sda_low | (sda_oe & ~sda_out));
    int n_mismatch = 0;
    int comparisons = 0;

    // ------------------------------------------------------------
    // Clock, design and master model
    // ------------------------------------------------------------
    always #10 sys_clk = ~sys_clk;

    xp_i2c_cfg_slave uut (
        .sys_clk(sys_clk),
        .reset(reset),
        .scl_clk(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_strap(addr_strap),
        .sync_tap_sel(sync_tap_sel),
        .link_busy(link_busy)
    );

    xp_master_model master (
        .scl(scl),
        .sda_low(m_sda_low),
        .sda_wire(sda_wire)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait for the end of a transfer
    task automatic wait_idle();
        int k;
        k = 0;
        while (link_busy !== 1'b0 && k < 50) begin
            @(posedge sys_clk);
            k++;
        end
        // Bound used up: count it and close the run
        if (link_busy !== 1'b0) begin
            n_mismatch++;
            $display("[ERR] t=%0t busy wait expired got %h exp 0", $time, link_busy);
            finish_test();
        end else begin
            check({7'h0, link_busy}, 8'h00, "busy after stop");
        end
    endtask

    // Write transfer: address, pointer, n data bytes (at most two), stop
    task automatic write_regs(input logic [6:0] a, input logic [7:0] ptr, input logic [7:0] d0,
                              input logic [7:0] d1, input int n, input logic exp_ack);
        logic ack;
        master.start_cond();
        check({7'h0, link_busy}, 8'h01, "busy after start");
        master.send_byte({a, 1'b0}, ack);
        check({7'h0, ack}, {7'h0, exp_ack}, "address ack");
        master.send_byte(ptr, ack);
        check({7'h0, ack}, {7'h0, exp_ack}, "pointer ack");
        if (n > 0) begin
            master.send_byte(d0, ack);
            check({7'h0, ack}, {7'h0, exp_ack}, "data ack");
        end
        if (n > 1) begin
            master.send_byte(d1, ack);
            check({7'h0, ack}, {7'h0, exp_ack}, "data ack");
        end
        master.stop_cond();
        wait_idle();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        check({7'h0, sda_oe}, 8'h00, "oe at reset");
        check({3'h0, sync_tap_sel}, 8'h00, "tap at reset");
        check({7'h0, link_busy}, 8'h00, "busy at reset");
        $display("test_reset done");
    endtask

    task automatic test_single_write();
        write_regs(7'h00, TAP_SEL_REG, 8'h05, 8'h00, 1, 1'b1);
        check({3'h0, sync_tap_sel}, 8'h05, "tap select");
        $display("test_single_write done");
    endtask

    task automatic test_auto_inc();
        write_regs(7'h00, TAP_SEL_REG - 8'h01, 8'hAA, 8'h13, 2, 1'b1);
        check({3'h0, sync_tap_sel}, 8'h13, "tap after increment");
        $display("test_auto_inc done");
    endtask

    task automatic test_foreign();
        logic [6:0] bad [3];
        bad = '{7'h04, 7'h01, 7'h40};
        foreach (bad[i]) begin
            write_regs(bad[i], TAP_SEL_REG, 8'h1F, 8'h00, 1, 1'b0);
        end
        check({3'h0, sync_tap_sel}, 8'h13, "tap untouched");
        $display("test_foreign done");
    endtask

    task automatic test_read();
        logic ack;
        logic [7:0] v;
        write_regs(7'h00, TAP_SEL_REG - 8'h01, 8'h00, 8'h00, 0, 1'b1);
        master.start_cond();
        master.send_byte(8'h01, ack);
        check({7'h0, ack}, 8'h01, "read address ack");
        master.recv_byte(1'b1, v);
        check(v, 8'hAA, "first read byte");
        master.recv_byte(1'b0, v);
        check(v, 8'h13, "second read byte");
        master.stop_cond();
        wait_idle();
        $display("test_read done");
    endtask

    task automatic test_straps();
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk);
            #1 addr_strap = s[1:0];
            repeat (10) @(posedge sys_clk);
            write_regs({5'h00, s[1:0] ^ 2'h1}, TAP_SEL_REG, 8'h1E, 8'h00, 1, 1'b0);
            write_regs({SLV_ADDR_HI, s[1:0]}, TAP_SEL_REG, 8'h10 + s[7:0], 8'h00, 1, 1'b1);
            check({3'h0, sync_tap_sel}, 8'h10 + s[7:0], "tap per strap");
        end
        $display("test_straps done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        // Raise reset after time zero so the link-side flops see an edge
        #1 reset = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1 reset = 1'b0;
        repeat (8) @(posedge sys_clk);
        test_reset();
        test_single_write();
        test_auto_inc();
        test_foreign();
        test_read();
        test_straps();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        $display("[ERR] t=%0t watchdog expired", $time);
        finish_test();
    end
endmodule
